/* mls_regs.v */
// Margin-low setpoint and output slew-rate command registers with target ramping.
// Assumes command-level word accesses decoded by the PMBus engine on core_clk,
// and an NVM controller that pulses restore and store on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "mls_regs.vh"

module mls_regs #(
  parameter [15:0] STEP_COST = `MLS_CYCLES_PER_US
) (
  input  wire              core_clk,
  input  wire              rst,
  input  wire [7:0]        cmd_code,
  input  wire              wr_strobe,
  input  wire [15:0]       wr_data,
  input  wire              rd_strobe,
  output reg  [15:0]       rd_data,
  output reg               rd_valid,
  input  wire              nvm_restore,
  input  wire              low_margin_default_bit,
  input  wire [2:0]        nvm_rate_setting,
  input  wire              nvm_store,
  output reg               store_default_bit,
  output reg  [2:0]        store_rate_setting,
  output reg               store_valid,
  input  wire              relative_format,
  input  wire [1:0]        margin_mode,
  input  wire [15:0]       vout_command,
  input  wire [15:0]       margin_high_setpoint,
  input  wire signed [15:0] vout_trim,
  input  wire [16:0]       vout_limit_min,
  input  wire [16:0]       vout_limit_max,
  input  wire              onoff_ramp_active,
  input  wire              status_clear,
  output reg               status_invalid_data,
  output reg               host_alert,
  output reg  [2:0]        applied_rate_setting,
  output wire signed [16:0] output_target,
  output wire              slew_active
);

  // ==========================================================
  // Register state
  reg [`MLS_ML_MSB:0]         margin_low;
  reg [`MLS_SR_MANT_W-1:0]    rate_mantissa;
  reg signed [16:0]           goal;

  wire [2:0] quant_setting;
  wire [7:0] quant_rate;

  // ==========================================================
  // Range check for a margin-low write
  wire signed [16:0] trim_ext      = {vout_trim[15], vout_trim};
  wire signed [16:0] wr_margin_sum = $signed({7'h00, wr_data[`MLS_ML_MSB:0]}) + trim_ext;
  wire               wr_in_range   = (wr_margin_sum >= $signed(vout_limit_min)) &&
                                     (wr_margin_sum <= $signed(vout_limit_max));
  wire               wr_margin_low = wr_strobe && (cmd_code == `MLS_CMD_MARGIN_LOW);
  wire               wr_slew       = wr_strobe && (cmd_code == `MLS_CMD_SLEW_RATE);
  wire               invalid_write = wr_margin_low && !wr_in_range;

  // ==========================================================
  // Margin-low setpoint
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      margin_low <= `MLS_ML_DFLT_BIT0;
    end else if (nvm_restore) begin
      margin_low <= low_margin_default_bit ? `MLS_ML_DFLT_BIT1 : `MLS_ML_DFLT_BIT0;
    end else if (wr_margin_low && wr_in_range) begin
      margin_low <= wr_data[`MLS_ML_MSB:0];
    end
  end

  // ==========================================================
  // Slew-rate mantissa
  reg [7:0] restore_mantissa;
  always @* begin
    case (nvm_rate_setting)
      3'h0:    restore_mantissa = `MLS_SR_RATE0;
      3'h1:    restore_mantissa = `MLS_SR_RATE1;
      3'h2:    restore_mantissa = `MLS_SR_RATE2;
      3'h3:    restore_mantissa = `MLS_SR_RATE3;
      3'h4:    restore_mantissa = `MLS_SR_RATE4;
      3'h5:    restore_mantissa = `MLS_SR_RATE5;
      3'h6:    restore_mantissa = `MLS_SR_RATE6;
      default: restore_mantissa = `MLS_SR_RATE7;
    endcase
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rate_mantissa <= `MLS_SR_RATE0;
    end else if (nvm_restore) begin
      rate_mantissa <= restore_mantissa;
    end else if (wr_slew) begin
      // Only the low byte lands; upper bits of the word are dropped
      rate_mantissa <= wr_data[7:0];
    end
  end

  mls_slew_quant u_quant (
    .mantissa (rate_mantissa),
    .setting  (quant_setting),
    .rate     (quant_rate)
  );

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      applied_rate_setting <= 3'h0;
    end else begin
      applied_rate_setting <= quant_setting;
    end
  end

  // ==========================================================
  // Register reads
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data  <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_strobe;
      if (rd_strobe) begin
        case (cmd_code)
          `MLS_CMD_MARGIN_LOW: rd_data <= {6'h00, margin_low};
          `MLS_CMD_SLEW_RATE:  rd_data <= {`MLS_SR_EXP_VALUE, 3'h0, rate_mantissa};
          default:             rd_data <= 16'h0000;
        endcase
      end
    end
  end

  // ==========================================================
  // Invalid-data status and host alert
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_invalid_data <= 1'b0;
      host_alert          <= 1'b0;
    end else if (invalid_write) begin
      // A new fault outranks a clear in the same cycle
      status_invalid_data <= 1'b1;
      host_alert          <= 1'b1;
    end else if (status_clear) begin
      status_invalid_data <= 1'b0;
      host_alert          <= 1'b0;
    end
  end

  // ==========================================================
  // NVM store image
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      store_default_bit  <= 1'b0;
      store_rate_setting <= 3'h0;
      store_valid        <= 1'b0;
    end else begin
      store_valid <= nvm_store;
      if (nvm_store) begin
        store_default_bit  <= (margin_low < `MLS_ML_STORE_THRESH);
        store_rate_setting <= quant_setting;
      end
    end
  end

  // ==========================================================
  // Output goal selection
  wire signed [16:0] low_goal  = relative_format ?
                                 ($signed({7'h00, margin_low}) + trim_ext) :
                                 ($signed({1'b0, vout_command}) + trim_ext);
  wire signed [16:0] high_goal = $signed({1'b0, margin_high_setpoint}) + trim_ext;
  wire signed [16:0] nom_goal  = $signed({1'b0, vout_command}) + trim_ext;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      goal <= 17'h00000;
    end else begin
      case (margin_mode)
        `MLS_MRG_LOW:  goal <= low_goal;
        `MLS_MRG_HIGH: goal <= high_goal;
        default:       goal <= nom_goal;
      endcase
    end
  end

  // ==========================================================
  // Slewed target
  mls_target_ramp #(
    .TW        (17),
    .STEP_COST (STEP_COST)
  ) u_ramp (
    .core_clk (core_clk),
    .rst      (rst),
    .goal     (goal),
    .rate     (quant_rate),
    .bypass   (onoff_ramp_active),
    .target   (output_target),
    .ramping  (slew_active)
  );

endmodule

`default_nettype wire

/* mls_regs.vh */
// Constants for the margin-low setpoint and output slew-rate command pair.
// Assumes a single 40 MHz core clock; included by every design file of the block.
`ifndef MLS_REGS_VH
`define MLS_REGS_VH

// ==========================================================
// Command codes
`define MLS_CMD_MARGIN_LOW    8'h26
`define MLS_CMD_SLEW_RATE     8'h27

// ==========================================================
// Margin-low setpoint word layout
`define MLS_ML_MSB            9
`define MLS_ML_W              10
`define MLS_ML_DFLT_BIT0      10'd496
`define MLS_ML_DFLT_BIT1      10'd488
`define MLS_ML_STORE_THRESH   10'd492

// ==========================================================
// Slew-rate word layout
`define MLS_SR_EXP_MSB        15
`define MLS_SR_EXP_LSB        11
`define MLS_SR_EXP_VALUE      5'h1d
`define MLS_SR_MANT_W         8

// Range bounds of the eight supported slew settings (lower limits)
`define MLS_SR_BOUND1         8'd8
`define MLS_SR_BOUND2         8'd15
`define MLS_SR_BOUND3         8'd30
`define MLS_SR_BOUND4         8'd42
`define MLS_SR_BOUND5         8'd62
`define MLS_SR_BOUND6         8'd84
`define MLS_SR_BOUND7         8'd144

// Applied rate per setting in 0.125 mV/us units; also the restore mantissa
`define MLS_SR_RATE0          8'd5
`define MLS_SR_RATE1          8'd10
`define MLS_SR_RATE2          8'd20
`define MLS_SR_RATE3          8'd39
`define MLS_SR_RATE4          8'd52
`define MLS_SR_RATE5          8'd78
`define MLS_SR_RATE6          8'd104
`define MLS_SR_RATE7          8'd156

// ==========================================================
// Margin mode codes of the operation margin field
`define MLS_MRG_NONE          2'b00
`define MLS_MRG_LOW           2'b01
`define MLS_MRG_HIGH          2'b10

// ==========================================================
// Timing
`define MLS_CLK_PERIOD_NS     25
`define MLS_US_NS             1000
// Core clock cycles in one microsecond at the 25 ns period
`define MLS_CYCLES_PER_US     16'd40

`endif

/* mls_slew_quant.v */
// Maps a slew-rate mantissa onto one of eight supported settings.
// Pure combinational; the caller registers the setting and feeds the rate straight to the ramp.
`timescale 1ns/100ps
`default_nettype none
`include "mls_regs.vh"

module mls_slew_quant (
  input  wire [7:0] mantissa,
  output reg  [2:0] setting,
  output reg  [7:0] rate
);

  always @* begin
    if (mantissa < `MLS_SR_BOUND1) begin
      setting = 3'h0;
    end else if (mantissa < `MLS_SR_BOUND2) begin
      setting = 3'h1;
    end else if (mantissa < `MLS_SR_BOUND3) begin
      setting = 3'h2;
    end else if (mantissa < `MLS_SR_BOUND4) begin
      setting = 3'h3;
    end else if (mantissa < `MLS_SR_BOUND5) begin
      setting = 3'h4;
    end else if (mantissa < `MLS_SR_BOUND6) begin
      setting = 3'h5;
    end else if (mantissa < `MLS_SR_BOUND7) begin
      setting = 3'h6;
    end else begin
      setting = 3'h7;
    end
  end

  always @* begin
    case (setting)
      3'h0:    rate = `MLS_SR_RATE0;
      3'h1:    rate = `MLS_SR_RATE1;
      3'h2:    rate = `MLS_SR_RATE2;
      3'h3:    rate = `MLS_SR_RATE3;
      3'h4:    rate = `MLS_SR_RATE4;
      3'h5:    rate = `MLS_SR_RATE5;
      3'h6:    rate = `MLS_SR_RATE6;
      default: rate = `MLS_SR_RATE7;
    endcase
  end

endmodule

`default_nettype wire

/* mls_target_ramp.v */
// Moves the applied output target toward a goal one LSB at a time; bypass loads the goal at once.
// Assumes rate in 0.125 mV/us units and a step cost of one LSB worth of rate-cycles.
`timescale 1ns/100ps
`default_nettype none
`include "mls_regs.vh"

module mls_target_ramp #(
  parameter        TW        = 17,
  parameter [15:0] STEP_COST = 16'd40
) (
  input  wire                 core_clk,
  input  wire                 rst,
  input  wire signed [TW-1:0] goal,
  input  wire [7:0]           rate,
  input  wire                 bypass,
  output reg  signed [TW-1:0] target,
  output reg                  ramping
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_UP   = 3'b010;
  localparam [2:0] ST_DOWN = 3'b100;

  reg [2:0]  state;
  reg [15:0] acc;
  wire [15:0] acc_sum = acc + {8'h00, rate};
  wire        step    = (acc_sum >= STEP_COST);
  // Capped so a rate above one step per cycle cannot wrap the accumulator
  wire [15:0] acc_left = acc_sum - STEP_COST;
  wire [15:0] acc_next = (acc_left > STEP_COST) ? STEP_COST : acc_left;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state   <= ST_IDLE;
      acc     <= 16'h0000;
      target  <= {TW{1'b0}};
      ramping <= 1'b0;
    end else if (bypass) begin
      // On/off sequencing owns the target; no programmed slew here
      state   <= ST_IDLE;
      acc     <= 16'h0000;
      target  <= goal;
      ramping <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          acc <= 16'h0000;
          if (goal > target) begin
            state   <= ST_UP;
            ramping <= 1'b1;
          end else if (goal < target) begin
            state   <= ST_DOWN;
            ramping <= 1'b1;
          end
        end
        ST_UP: begin
          if (goal <= target) begin
            state   <= ST_IDLE;
            ramping <= 1'b0;
          end else begin
            acc <= step ? acc_next : acc_sum;
            if (step) begin
              target <= target + {{(TW-1){1'b0}}, 1'b1};
            end
          end
        end
        ST_DOWN: begin
          if (goal >= target) begin
            state   <= ST_IDLE;
            ramping <= 1'b0;
          end else begin
            acc <= step ? acc_next : acc_sum;
            if (step) begin
              target <= target - {{(TW-1){1'b0}}, 1'b1};
            end
          end
        end
        default: begin
          state   <= ST_IDLE;
          ramping <= 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* mls_regs_chk.sv */
// Assertions on the ports of the margin-low and slew-rate register block.
// Bound to every mls_regs instance; one clock, core_clk, reset rst.
`timescale 1ns/100ps
`default_nettype none
module mls_regs_chk (
  input wire logic               core_clk,
  input wire logic               rst,
  input wire logic [7:0]         cmd_code,
  input wire logic               wr_strobe,
  input wire logic               rd_strobe,
  input wire logic [15:0]        rd_data,
  input wire logic               rd_valid,
  input wire logic               nvm_restore,
  input wire logic               nvm_store,
  input wire logic [2:0]         store_rate_setting,
  input wire logic               store_valid,
  input wire logic               onoff_ramp_active,
  input wire logic               status_clear,
  input wire logic               status_invalid_data,
  input wire logic               host_alert,
  input wire logic [2:0]         applied_rate_setting,
  input wire logic signed [16:0] output_target,
  input wire logic               slew_active
);
  function automatic logic [2:0] q(input logic [7:0] m);
    q = (m >= 8'h90) ? 3'h7 : (m >= 8'h54) ? 3'h6 : (m >= 8'h3e) ? 3'h5 : (m >= 8'h2a) ? 3'h4 :
        (m >= 8'h1e) ? 3'h3 : (m >= 8'h0f) ? 3'h2 : (m >= 8'h08) ? 3'h1 : 3'h0;
  endfunction

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // ====
  // Register port
  a_rd_answer: assert property (rd_strobe |=> rd_valid) else $error("read not answered");
  a_rd_cause: assert property (rd_valid |-> $past(rd_strobe)) else $error("stray read valid");
  a_ml_reserved: assert property (rd_valid && $past(cmd_code) == 8'h26 |-> rd_data[15:10] == 6'h0)
    else $error("margin word upper bits set");
  a_sr_fixed: assert property (rd_valid && $past(cmd_code) == 8'h27 |-> rd_data[15:8] == 8'he8)
    else $error("slew word upper byte wrong");
  a_rate_quant: assert property (rd_valid && $past(cmd_code) == 8'h27 && !$past(wr_strobe)
    && !$past(nvm_restore) |-> applied_rate_setting == q(rd_data[7:0])) else $error("rate setting wrong");
  a_store_image: assert property (nvm_store && !wr_strobe && !nvm_restore |=>
    store_valid && store_rate_setting == applied_rate_setting) else $error("store image wrong");

  // ====
  // Status and ramp
  a_inv_hold: assert property (status_invalid_data && !status_clear |=> status_invalid_data)
    else $error("status dropped");
  a_alert_pair: assert property (host_alert == status_invalid_data) else $error("alert differs");
  a_inv_cause: assert property ($rose(status_invalid_data) |-> $past(wr_strobe)
    && $past(cmd_code) == 8'h26) else $error("status without margin write");
  a_clear_works: assert property (status_clear && !wr_strobe |=> !status_invalid_data)
    else $error("status not cleared");
  a_one_step: assert property (!$past(onoff_ramp_active) |->
    $unsigned(output_target - $past(output_target) + 17'sd1) <= 17'h2) else $error("target jumped");

  c_refused: cover property ($rose(status_invalid_data));
  c_ramp: cover property ($rose(slew_active));
  c_store: cover property (store_valid);
endmodule
bind mls_regs mls_regs_chk chk_u (.core_clk, .rst, .cmd_code, .wr_strobe, .rd_strobe, .rd_data,
  .rd_valid, .nvm_restore, .nvm_store, .store_rate_setting, .store_valid, .onoff_ramp_active,
  .status_clear, .status_invalid_data, .host_alert, .applied_rate_setting, .output_target, .slew_active);
`default_nettype wire

/* mls_host.sv */
// Host controller model issuing whole-word command writes and reads.
// Strobes are one-cycle pulses launched just after a rising edge of core_clk.
`timescale 1ns/100ps
`default_nettype none
module mls_host (
  input  wire logic        core_clk,
  output var  logic [7:0]  cmd_code,
  output var  logic        wr_strobe,
  output var  logic [15:0] wr_data,
  output var  logic        rd_strobe,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid
);
  initial begin
    cmd_code = 8'h0;
    wr_strobe = 1'b0;
    wr_data = 16'h0;
    rd_strobe = 1'b0;
  end

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge core_clk);
    cmd_code <= c;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge core_clk);
    wr_strobe <= 1'b0;
    // Released data no longer carries the word
    wr_data <= ~d;
  endtask

  task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic v);
    @(posedge core_clk);
    cmd_code <= c;
    rd_strobe <= 1'b1;
    @(posedge core_clk);
    rd_strobe <= 1'b0;
    @(negedge core_clk);
    d = rd_data;
    v = rd_valid;
  endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for mls_regs, driven through the host model.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic               core_clk, rst, wr_strobe, rd_strobe, rd_valid, nvm_restore, nvm_store;
  logic               low_margin_default_bit, store_default_bit, store_valid, onoff_ramp_active;
  logic               status_clear, status_invalid_data, host_alert, slew_active, relative_format;
  logic [7:0]         cmd_code;
  logic [15:0]        wr_data, rd_data, vout_command;
  logic [2:0]         nvm_rate_setting, store_rate_setting, applied_rate_setting;
  logic [1:0]         margin_mode;
  logic [16:0]        vout_limit_max;
  logic signed [15:0] vout_trim;
  logic signed [16:0] output_target;
  int                 n_mismatch = 0, checked = 0, cyc = 0, n;
  logic [7:0]         ms [16] = '{8'h00, 8'h07, 8'h08, 8'h0e, 8'h0f, 8'h1d, 8'h1e, 8'h29,
                                  8'h2a, 8'h3d, 8'h3e, 8'h53, 8'h54, 8'h8f, 8'h90, 8'hff};
  logic [7:0]         rmt [8] = '{8'h05, 8'h0a, 8'h14, 8'h27, 8'h34, 8'h4e, 8'h68, 8'h9c};
  logic [9:0]         sv [4] = '{10'h3ff, 10'h1ec, 10'h1eb, 10'h000};

  mls_host host_u (.core_clk, .cmd_code, .wr_strobe, .wr_data, .rd_strobe, .rd_data, .rd_valid);
  mls_regs #(.STEP_COST(16'h28)) dut_u (.core_clk, .rst, .cmd_code, .wr_strobe, .wr_data, .rd_strobe,
    .rd_data, .rd_valid, .nvm_restore, .low_margin_default_bit, .nvm_rate_setting, .nvm_store,
    .store_default_bit, .store_rate_setting, .store_valid, .relative_format, .margin_mode,
    .vout_command, .margin_high_setpoint(16'h210), .vout_trim, .vout_limit_min(17'h0), .vout_limit_max,
    .onoff_ramp_active, .status_clear, .status_invalid_data, .host_alert, .applied_rate_setting,
    .output_target, .slew_active);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ====
  // Shared tasks
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_in(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic rdc(input logic [7:0] c, input logic [16:0] e);
    logic [15:0] d;
    logic        v;
    host_u.rd(c, d, v);
    chk(v, 17'h1);
    chk(d, e);
  endtask
  task automatic reach(input logic [16:0] t);
    n = 0;
    while (output_target !== t && n < 1000) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      give_verdict;
    end
  end

  // ====
  // Tests
  initial begin
    {rst, nvm_restore, nvm_store, low_margin_default_bit, status_clear} = 5'h10;
    {nvm_rate_setting, margin_mode, vout_trim} = 0;
    onoff_ramp_active = 1'b1;
    relative_format = 1'b1;
    vout_command = 16'h1f0;
    vout_limit_max = 17'h3ff;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    rdc(8'h26, 17'h1f0);
    rdc(8'h27, 17'he805);
    rdc(8'h99, 17'h0);
    chk(output_target, 17'h1f0);
    $display("test reset done");
    for (int s = 0; s < 8; s++) begin
      @(posedge core_clk);
      nvm_rate_setting <= 3'(s);
      low_margin_default_bit <= s[0];
      nvm_restore <= 1'b1;
      @(posedge core_clk);
      nvm_restore <= 1'b0;
      rdc(8'h27, 17'he800 | rmt[s]);
      rdc(8'h26, s[0] ? 17'h1e8 : 17'h1f0);
      chk(applied_rate_setting, 17'(s));
    end
    $display("test restore done");
    for (int i = 0; i < 16; i++) begin
      host_u.wr(8'h27, {8'hff, ms[i]});
      rdc(8'h27, 17'he800 | ms[i]);
      chk(applied_rate_setting, 17'(i >> 1));
      chk(status_invalid_data, 17'h0);
    end
    $display("test slew done");
    for (int i = 0; i < 4; i++) begin
      host_u.wr(8'h26, {6'h3f, sv[i]});
      rdc(8'h26, 17'(sv[i]));
      @(posedge core_clk) nvm_store <= 1'b1;
      @(posedge core_clk) nvm_store <= 1'b0;
      @(negedge core_clk);
      chk(store_valid, 17'h1);
      chk(store_default_bit, 17'(sv[i] < 10'h1ec));
      chk(store_rate_setting, 17'h7);
    end
    $display("test store done");
    @(posedge core_clk) vout_trim <= 16'sh4;
    vout_limit_max <= 17'h1f4;
    host_u.wr(8'h26, 16'h1f0);
    rdc(8'h26, 17'h1f0);
    chk(status_invalid_data, 17'h0);
    host_u.wr(8'h26, 16'h1f1);
    rdc(8'h26, 17'h1f0);
    chk({status_invalid_data, host_alert}, 17'h3);
    @(posedge core_clk) status_clear <= 1'b1;
    @(posedge core_clk) status_clear <= 1'b0;
    @(negedge core_clk);
    chk({status_invalid_data, host_alert}, 17'h0);
    @(posedge core_clk) vout_trim <= -16'sh10;
    host_u.wr(8'h26, 16'h0008);
    rdc(8'h26, 17'h1f0);
    chk({status_invalid_data, host_alert}, 17'h3);
    @(posedge core_clk) status_clear <= 1'b1;
    @(posedge core_clk) status_clear <= 1'b0;
    $display("test refusal done");
    @(posedge core_clk) vout_limit_max <= 17'h3ff;
    vout_trim <= 16'sh2;
    repeat (4) @(posedge core_clk);
    chk(output_target, 17'h1f2);
    onoff_ramp_active <= 1'b0;
    host_u.wr(8'h27, 16'h0005);
    host_u.wr(8'h26, 16'h1e6);
    @(posedge core_clk) margin_mode <= 2'h1;
    reach(17'h1e8);
    chk_in(n, 70, 90);
    chk(slew_active, 17'h1);
    @(negedge core_clk);
    chk(slew_active, 17'h0);
    host_u.wr(8'h27, 16'h009c);
    @(posedge core_clk) margin_mode <= 2'h0;
    reach(17'h1f2);
    chk_in(n, 10, 16);
    $display("test ramp done");
    @(posedge core_clk) onoff_ramp_active <= 1'b1;
    relative_format <= 1'b0;
    margin_mode <= 2'h1;
    repeat (4) @(negedge core_clk);
    chk(output_target, 17'h1f2);
    @(posedge core_clk) relative_format <= 1'b1;
    repeat (4) @(negedge core_clk);
    chk(output_target, 17'h1e8);
    @(posedge core_clk) margin_mode <= 2'h2;
    repeat (4) @(negedge core_clk);
    chk(output_target, 17'h212);
    $display("test format done");
    give_verdict;
  end
endmodule
`default_nettype wire
